// ===== design/amc_defines.svh
`ifndef AMC_DEFINES_SVH
`define AMC_DEFINES_SVH

// register offsets on the serial control port
`define AMC_OFS_DAC_CONFIG 8'h5d
`define AMC_OFS_PIN_DIRECTION 8'h60
`define AMC_OFS_PIN_FUNCTION 8'h61
`define AMC_OFS_DSP_BYPASS 8'h66
`define AMC_OFS_SILICON_ID 8'h67
`define AMC_OFS_POWER_STATE 8'h68
`define AMC_OFS_MUTE_STATUS 8'h69

// reset values
`define AMC_RST_DAC_CONFIG 8'hf8
`define AMC_RST_PIN_DIRECTION 1'h0
`define AMC_RST_PIN_FUNCTION 5'h00
`define AMC_RST_DSP_BYPASS 4'h0

// field positions
`define AMC_POS_PIN_DIR 0
`define AMC_POS_FIR_BYPASS 2

// multipurpose pin function codes
`define AMC_PIN_OFF 5'h00
`define AMC_PIN_MUTE_BOTH 5'h03
`define AMC_PIN_MUTE_LEFT 5'h04
`define AMC_PIN_MUTE_RIGHT 5'h05
`define AMC_PIN_CLOCK_BAD 5'h06
`define AMC_PIN_FAULT 5'h0b

// dither amplitude exponent bases (amplitude is minus 2 to the minus exponent)
`define AMC_DITHER_EXP_HI_BASE 5'd7
`define AMC_DITHER_EXP_LO_BASE 5'd13

// clock rates in hertz
`define AMC_SYS_CLK_HZ 200000000
`define AMC_MOD_FAST_HZ 6144000
`define AMC_MOD_SLOW_HZ 3072000

`endif

// ===== design/amc_pkg.sv
package amc_pkg;

   // modulator configuration, laid out as the register byte
   typedef struct packed {
      logic slow_clk;
      logic [1:0] dither_en;
      logic [2:0] dither_level;
      logic [1:0] matching_sel;
   } amc_dac_cfg_t;

   // dsp path bypass controls
   typedef struct packed {
      logic unique_coef;
      logic fir_bypass;
      logic drc_bypass;
      logic eq_bypass;
   } amc_dsp_bypass_t;

   // live status from the rest of the device
   typedef struct packed {
      logic mute_left;
      logic mute_right;
      logic clock_error;
      logic clock_missing;
      logic fault_indication_n;
   } amc_status_t;

   // one register access from the control port slave
   typedef struct packed {
      logic wr;
      logic rd;
      logic [7:0] addr;
      logic [7:0] wdata;
   } amc_reg_req_t;

endpackage

// ===== design/amc_mod_clock.sv
`include "amc_defines.svh"

module amc_mod_clock #(
   parameter int ACC_W = 32
) (
   input wire logic sys_clk,
   input wire logic rst_b,
   input wire logic slow_sel,
   output logic tick
);
   import amc_pkg::*;

   localparam logic [63:0] INC_FAST = (64'(`AMC_MOD_FAST_HZ) << ACC_W) / 64'(`AMC_SYS_CLK_HZ);
   localparam logic [63:0] INC_SLOW = (64'(`AMC_MOD_SLOW_HZ) << ACC_W) / 64'(`AMC_SYS_CLK_HZ);

   logic [ACC_W-1:0] acc_q;
   logic tick_q;
   logic [ACC_W-1:0] inc;
   logic [ACC_W:0] sum;

   // fractional accumulator, carry out is the modulator clock enable
   assign inc = slow_sel ? INC_SLOW[ACC_W-1:0] : INC_FAST[ACC_W-1:0];
   assign sum = {1'b0, acc_q} + {1'b0, inc};
   assign tick = tick_q;

   always_ff @(posedge sys_clk or negedge rst_b) begin
      if (!rst_b) begin
         acc_q <= '0;
         tick_q <= 1'b0;
      end else begin
         acc_q <= sum[ACC_W-1:0];
         tick_q <= sum[ACC_W];
      end
   end

   // helper: spacing between enables while the rate select holds
   logic [7:0] gap_q;
   logic valid_q;
   logic sel_q;
   always_ff @(posedge sys_clk or negedge rst_b) begin
      if (!rst_b) begin
         gap_q <= 8'h00;
         valid_q <= 1'b0;
         sel_q <= 1'b1;
      end else begin
         sel_q <= slow_sel;
         gap_q <= tick_q ? 8'h00 : gap_q + 8'h01;
         valid_q <= (sel_q != slow_sel) ? 1'b0 : (tick_q ? 1'b1 : valid_q);
      end
   end

   property p_mod_rate;
      @(posedge sys_clk) disable iff (!rst_b)
      (tick_q && valid_q && sel_q == slow_sel) |->
         (sel_q ? (gap_q >= 8'd64 && gap_q <= 8'd65) : (gap_q >= 8'd31 && gap_q <= 8'd32));
   endproperty
   a_mod_rate: assert property (p_mod_rate) else $error("modulator enable spacing wrong");
endmodule

// ===== design/amc_pin_mux.sv
`include "amc_defines.svh"

module amc_pin_mux (
   input wire logic sys_clk,
   input wire logic rst_b,
   input wire logic [4:0] pin_func,
   input amc_pkg::amc_status_t status,
   output logic pin_out
);
   import amc_pkg::*;

   logic sel_both;
   logic sel_left;
   logic sel_right;
   logic sel_clock;
   logic sel_fault;
   logic pin_d;
   logic pin_q;

   // function code decode, unknown and reserved codes drive low
   assign sel_both = (pin_func == `AMC_PIN_MUTE_BOTH);
   assign sel_left = (pin_func == `AMC_PIN_MUTE_LEFT);
   assign sel_right = (pin_func == `AMC_PIN_MUTE_RIGHT);
   assign sel_clock = (pin_func == `AMC_PIN_CLOCK_BAD);
   assign sel_fault = (pin_func == `AMC_PIN_FAULT);

   // flag selection, off code and reserved codes give a low pin
   assign pin_d = (sel_both & status.mute_left & status.mute_right)
      | (sel_left & status.mute_left)
      | (sel_right & status.mute_right)
      | (sel_clock & (status.clock_error | status.clock_missing))
      | (sel_fault & status.fault_indication_n);
   assign pin_out = pin_q;

   always_ff @(posedge sys_clk or negedge rst_b) begin
      if (!rst_b) begin
         pin_q <= 1'b0;
      end else begin
         pin_q <= pin_d;
      end
   end
endmodule

// ===== design/amc_misc_regs.sv
// Notes on behaviour
// - modulator enable runs at 6.144MHz with select 0, 3.072MHz with 1; resets 1
// - dither enable: 00 none, 01 main, 10 second, 11 both; resets both
// - dither level 100..111 gives 2^-7..2^-10, 000..011 gives 2^-13..2^-16
// - element matching enabled on select 00, disabled on 11; resets 00
// - address pin is input while direction bit 0, driven output when 1
// - code 00011 drives a flag high only while both channels are muted
// - code 00100 outputs left mute flag, code 00101 right mute flag
// - code 00110 drives clock invalid: clock error or clock missing
// - code 01011 outputs the active low fault; 00111 and 01001 reserved
// - bypass bit 2 set routes audio around the 128 tap fir
// - bypass bit 1 set skips compression in left and right channels only
// - bypass bit 0 set skips equalizer biquads in left and right only
// - power state reads 0 deep sleep, 1 sleep, 2 high impedance, 3 play
`include "amc_defines.svh"

module amc_misc_regs #(
   parameter logic [7:0] SILICON_ID = 8'h5a, // arbitrary value
   parameter int ACC_W = 32
) (
   input wire logic sys_clk,
   input wire logic rst_b,
   input amc_pkg::amc_reg_req_t reg_req,
   output logic [7:0] reg_rdata,
   output logic reg_rvalid,
   input amc_pkg::amc_status_t status,
   input wire logic [7:0] power_state_code,
   input wire logic addr_pin_in,
   output logic addr_pin_out,
   output logic addr_pin_oe_b,
   output logic addr_pin_level,
   output logic mod_clk_en,
   output logic dither_main_en,
   output logic dither_second_en,
   output logic [4:0] dither_exp,
   output logic dynamic_element_matching_en,
   output amc_pkg::amc_dsp_bypass_t dsp_bypass
);
   import amc_pkg::*;

   amc_dac_cfg_t dac_q;
   logic dir_q;
   logic [4:0] func_q;
   amc_dsp_bypass_t dsp_q;
   logic [7:0] rdata_q;
   logic rvalid_q;
   logic level_q;

   logic wr_dac;
   logic wr_dir;
   logic wr_func;
   logic wr_dsp;
   logic hit_dac;
   logic hit_dir;
   logic hit_func;
   logic hit_dsp;
   logic hit_id;
   logic hit_power;
   logic hit_mute;
   logic [7:0] rd_mux;

   // address decode
   assign hit_dac = (reg_req.addr == `AMC_OFS_DAC_CONFIG);
   assign hit_dir = (reg_req.addr == `AMC_OFS_PIN_DIRECTION);
   assign hit_func = (reg_req.addr == `AMC_OFS_PIN_FUNCTION);
   assign hit_dsp = (reg_req.addr == `AMC_OFS_DSP_BYPASS);
   assign hit_id = (reg_req.addr == `AMC_OFS_SILICON_ID);
   assign hit_power = (reg_req.addr == `AMC_OFS_POWER_STATE);
   assign hit_mute = (reg_req.addr == `AMC_OFS_MUTE_STATUS);

   // write strobes, read-only offsets ignore writes
   assign wr_dac = reg_req.wr & hit_dac;
   assign wr_dir = reg_req.wr & hit_dir;
   assign wr_func = reg_req.wr & hit_func;
   assign wr_dsp = reg_req.wr & hit_dsp;

   // writable fields, held until the next write or reset
   always_ff @(posedge sys_clk or negedge rst_b) begin
      if (!rst_b) begin
         dac_q <= amc_dac_cfg_t'(`AMC_RST_DAC_CONFIG);
         dir_q <= `AMC_RST_PIN_DIRECTION;
         func_q <= `AMC_RST_PIN_FUNCTION;
         dsp_q <= amc_dsp_bypass_t'(`AMC_RST_DSP_BYPASS);
      end else begin
         if (wr_dac) begin
            dac_q <= amc_dac_cfg_t'(reg_req.wdata);
         end
         if (wr_dir) begin
            dir_q <= reg_req.wdata[`AMC_POS_PIN_DIR];
         end
         if (wr_func) begin
            func_q <= reg_req.wdata[4:0];
         end
         if (wr_dsp) begin
            dsp_q <= amc_dsp_bypass_t'(reg_req.wdata[3:0]);
         end
      end
   end

   // read data select, reserved bits and unmapped offsets read zero
   assign rd_mux = hit_dac ? dac_q
      : hit_dir ? {7'h00, dir_q}
      : hit_func ? {3'h0, func_q}
      : hit_dsp ? {4'h0, dsp_q}
      : hit_id ? SILICON_ID
      : hit_power ? power_state_code
      : hit_mute ? {6'h00, status.mute_right, status.mute_left}
      : 8'h00;

   // read answer one cycle after the request
   always_ff @(posedge sys_clk or negedge rst_b) begin
      if (!rst_b) begin
         rdata_q <= 8'h00;
         rvalid_q <= 1'b0;
      end else begin
         rvalid_q <= reg_req.rd;
         if (reg_req.rd) begin
            rdata_q <= rd_mux;
         end
      end
   end
   assign reg_rdata = rdata_q;
   assign reg_rvalid = rvalid_q;

   // modulator controls from the configuration byte
   assign dither_main_en = dac_q.dither_en[0];
   assign dither_second_en = dac_q.dither_en[1];
   assign dither_exp = dac_q.dither_level[2]
      ? `AMC_DITHER_EXP_HI_BASE + {3'h0, dac_q.dither_level[1:0]}
      : `AMC_DITHER_EXP_LO_BASE + {3'h0, dac_q.dither_level[1:0]};
   assign dynamic_element_matching_en = (dac_q.matching_sel == 2'b00);
   assign dsp_bypass = dsp_q;

   // modulator clock enable generator
   amc_mod_clock #(
      .ACC_W(ACC_W)
   ) u_mod_clock (
      .sys_clk(sys_clk),
      .rst_b(rst_b),
      .slow_sel(dac_q.slow_clk),
      .tick(mod_clk_en)
   );

   // multipurpose pin flag selection
   amc_pin_mux u_pin_mux (
      .sys_clk(sys_clk),
      .rst_b(rst_b),
      .pin_func(func_q),
      .status(status),
      .pin_out(addr_pin_out)
   );

   // pin direction, enable is low while the pin is driven
   assign addr_pin_oe_b = ~dir_q;

   // pin level is sampled only while the pin is an input
   always_ff @(posedge sys_clk or negedge rst_b) begin
      if (!rst_b) begin
         level_q <= 1'b0;
      end else if (!dir_q) begin
         level_q <= addr_pin_in;
      end
   end
   assign addr_pin_level = level_q;

   default clocking cb @(posedge sys_clk);
   endclocking
   default disable iff (!rst_b);

   // modulator rate select follows a write
   property p_freq_write;
      wr_dac |=> (dac_q.slow_clk == $past(reg_req.wdata[7]));
   endproperty
   a_freq_write: assert property (p_freq_write) else $error("rate select not taken");

   // dither stages follow a write
   property p_dither_en;
      (wr_dac && reg_req.wdata[6:5] == 2'b10) |=> (!dither_main_en && dither_second_en);
   endproperty
   a_dither_en: assert property (p_dither_en) else $error("dither stage enables wrong");

   // dither level mapping
   property p_dither_level;
      (wr_dac && reg_req.wdata[4:2] == 3'b101) |=> (dither_exp == 5'd8);
   endproperty
   a_dither_level: assert property (p_dither_level) else $error("dither level high range wrong");

   property p_dither_low;
      (wr_dac && reg_req.wdata[4:2] == 3'b011) |=> (dither_exp == 5'd16);
   endproperty
   a_dither_low: assert property (p_dither_low) else $error("dither level low range wrong");

   // matching disabled on select 11
   property p_matching;
      (wr_dac && reg_req.wdata[1:0] == 2'b11) |=> !dynamic_element_matching_en;
   endproperty
   a_matching: assert property (p_matching) else $error("element matching not disabled");

   // pin driven one cycle after direction write of 1
   property p_pin_dir;
      (wr_dir && reg_req.wdata[0]) |=> !addr_pin_oe_b;
   endproperty
   a_pin_dir: assert property (p_pin_dir) else $error("pin not driven");

   // off code keeps the pin low
   property p_pin_off;
      (func_q == `AMC_PIN_OFF) [*2] |-> !addr_pin_out;
   endproperty
   a_pin_off: assert property (p_pin_off) else $error("pin not low when off");

   // both-muted flag needs both channels
   property p_pin_both;
      (func_q == `AMC_PIN_MUTE_BOTH && !func_q[2]) |=> (addr_pin_out == ($past(status.mute_left) && $past(status.mute_right)));
   endproperty
   a_pin_both: assert property (p_pin_both) else $error("both-muted flag wrong");

   // right mute flag on its code
   property p_pin_right;
      (func_q == `AMC_PIN_MUTE_RIGHT) |=> (addr_pin_out == $past(status.mute_right));
   endproperty
   a_pin_right: assert property (p_pin_right) else $error("right mute flag wrong");

   // clock invalid flag
   property p_pin_clock;
      (func_q == `AMC_PIN_CLOCK_BAD) |=> (addr_pin_out == ($past(status.clock_error) || $past(status.clock_missing)));
   endproperty
   a_pin_clock: assert property (p_pin_clock) else $error("clock invalid flag wrong");

   // fault passes through on its code
   property p_pin_fault;
      (func_q == `AMC_PIN_FAULT) |=> (addr_pin_out == $past(status.fault_indication_n));
   endproperty
   a_pin_fault: assert property (p_pin_fault) else $error("fault not on pin");

   // fir bypass follows a write
   property p_fir;
      wr_dsp |=> (dsp_bypass.fir_bypass == $past(reg_req.wdata[`AMC_POS_FIR_BYPASS]));
   endproperty
   a_fir: assert property (p_fir) else $error("fir bypass not taken");

   // power state read returns the live code
   property p_power_read;
      (reg_req.rd && hit_power) |=> (reg_rvalid && reg_rdata == $past(power_state_code));
   endproperty
   a_power_read: assert property (p_power_read) else $error("power state read wrong");

   // configuration holds without a write
   property p_hold;
      !wr_dac |=> (dac_q == $past(dac_q));
   endproperty
   a_hold: assert property (p_hold) else $error("configuration changed without write");

   // no dither stage on select 00
   property p_dither_none;
      (wr_dac && reg_req.wdata[6:5] == 2'b00) |=> (!dither_main_en && !dither_second_en);
   endproperty
   a_dither_none: assert property (p_dither_none) else $error("dither not disabled");

   // pin released to input after a direction write of 0
   property p_pin_input;
      (wr_dir && !reg_req.wdata[0]) |=> addr_pin_oe_b;
   endproperty
   a_pin_input: assert property (p_pin_input) else $error("pin not released");

   // input level frozen while the pin is driven
   property p_level_hold;
      dir_q |=> $stable(addr_pin_level);
   endproperty
   a_level_hold: assert property (p_level_hold) else $error("input level moved while driven");

   // left mute flag on its code
   property p_pin_left;
      (func_q == `AMC_PIN_MUTE_LEFT) |=> (addr_pin_out == $past(status.mute_left));
   endproperty
   a_pin_left: assert property (p_pin_left) else $error("left mute flag wrong");

   // reserved codes keep the pin low
   property p_pin_reserved;
      (func_q == 5'h07 || func_q == 5'h09) |=> !addr_pin_out;
   endproperty
   a_pin_reserved: assert property (p_pin_reserved) else $error("reserved code drove the pin");

   // coefficient sharing select follows a write
   property p_coef;
      wr_dsp |=> (dsp_bypass.unique_coef == $past(reg_req.wdata[3]));
   endproperty
   a_coef: assert property (p_coef) else $error("coefficient select not taken");

   // compression bypass follows a write
   property p_drc;
      wr_dsp |=> (dsp_bypass.drc_bypass == $past(reg_req.wdata[1]));
   endproperty
   a_drc: assert property (p_drc) else $error("compression bypass not taken");

   // equalizer bypass follows a write
   property p_eq;
      wr_dsp |=> (dsp_bypass.eq_bypass == $past(reg_req.wdata[0]));
   endproperty
   a_eq: assert property (p_eq) else $error("equalizer bypass not taken");

   // bypass controls hold without a write
   property p_dsp_hold;
      !wr_dsp |=> (dsp_bypass == $past(dsp_bypass));
   endproperty
   a_dsp_hold: assert property (p_dsp_hold) else $error("bypass changed without write");

   // main scenarios
   c_dac_write: cover property (wr_dac ##1 !dac_q.slow_clk);
   c_power_read: cover property (reg_req.rd && hit_power ##1 reg_rvalid);
   c_both_muted: cover property (func_q == `AMC_PIN_MUTE_BOTH ##1 addr_pin_out);
   c_pin_driven: cover property (!addr_pin_oe_b && addr_pin_out);
endmodule

// ===== test/amc_misc_regs_tb.sv
module testbench;
   timeunit 1ns;
   timeprecision 1ps;
   import amc_pkg::*;

   localparam logic [7:0] ID_VAL = 8'h3c; // arbitrary value

   logic sys_clk = 1'b0;
   logic rst_b = 1'b0;
   amc_reg_req_t reg_req = '0;
   logic [7:0] reg_rdata;
   logic reg_rvalid;
   amc_status_t status = 5'h01;
   logic [7:0] power_state_code = 8'h00;
   logic addr_pin_in = 1'b0;
   logic addr_pin_out, addr_pin_oe_b, addr_pin_level, mod_clk_en;
   logic dither_main_en, dither_second_en, dynamic_element_matching_en;
   logic [4:0] dither_exp;
   amc_dsp_bypass_t dsp_bypass;
   int n_fail = 0;
   int num_checks = 0;
   logic [4:0] codes [8] = '{5'h00, 5'h03, 5'h04, 5'h05, 5'h06, 5'h07, 5'h09, 5'h0b};

   // system clock, 5 ns period
   always #2.5 sys_clk = ~sys_clk;

   amc_misc_regs #(.SILICON_ID(ID_VAL), .ACC_W(32)) dut (
      .sys_clk(sys_clk),
      .rst_b(rst_b),
      .reg_req(reg_req),
      .reg_rdata(reg_rdata),
      .reg_rvalid(reg_rvalid),
      .status(status),
      .power_state_code(power_state_code),
      .addr_pin_in(addr_pin_in),
      .addr_pin_out(addr_pin_out),
      .addr_pin_oe_b(addr_pin_oe_b),
      .addr_pin_level(addr_pin_level),
      .mod_clk_en(mod_clk_en),
      .dither_main_en(dither_main_en),
      .dither_second_en(dither_second_en),
      .dither_exp(dither_exp),
      .dynamic_element_matching_en(dynamic_element_matching_en),
      .dsp_bypass(dsp_bypass)
   );

   // verdict and end of run
   task automatic print_verdict();
      $display("checks %0d mismatches %0d", num_checks, n_fail);
      if (n_fail == 0 && num_checks > 0) begin
         $display("== PASSED ==");
      end else begin
         $display("== FAILED ==");
      end
      $finish;
   endtask

   // compare one seen value against its expectation
   task automatic check(string nm, logic [7:0] seen, logic [7:0] exp);
      num_checks++;
      if (seen !== exp) begin
         n_fail++;
         $display("BAD %s expected %h seen %h", nm, exp, seen);
      end
   endtask

   // reset held for 16 cycles, released at a falling edge
   task automatic do_reset();
      rst_b = 1'b0;
      repeat (16) @(negedge sys_clk);
      rst_b = 1'b1;
   endtask

   // one-cycle write strobe
   task automatic reg_write(logic [7:0] a, logic [7:0] d);
      @(negedge sys_clk);
      reg_req = '{wr: 1'b1, rd: 1'b0, addr: a, wdata: d};
      @(negedge sys_clk);
      reg_req = '0;
   endtask

   // one-cycle read strobe, bounded wait for the answer
   task automatic reg_read(logic [7:0] a, logic [7:0] exp);
      int i;
      @(negedge sys_clk);
      reg_req = '{wr: 1'b0, rd: 1'b1, addr: a, wdata: 8'h00};
      @(negedge sys_clk);
      reg_req = '0;
      for (i = 0; i < 4 && reg_rvalid !== 1'b1; i++) @(negedge sys_clk);
      check("read valid", {7'h00, reg_rvalid}, 8'h01);
      if (reg_rvalid !== 1'b1) begin
         print_verdict();
      end else begin
         check("read data", reg_rdata, exp);
      end
   endtask

   // count modulator enables over 1000 cycles
   task automatic count_mod(int lo, string nm);
      int cnt;
      cnt = 0;
      repeat (1000) begin
         @(posedge sys_clk);
         #1;
         if (mod_clk_en === 1'b1) cnt++;
      end
      check(nm, 8'(cnt == lo || cnt == lo + 1), 8'h01);
   endtask

   function automatic logic exp_pin(logic [4:0] f, logic [4:0] s);
      case (f)
         5'h03: return s[4] & s[3];
         5'h04: return s[4];
         5'h05: return s[3];
         5'h06: return s[2] | s[1];
         5'h0b: return s[0];
         default: return 1'b0;
      endcase
   endfunction

   // main sequence
   initial begin
      do_reset();
      reg_read(8'h5d, 8'hf8);
      reg_read(8'h60, 8'h00);
      reg_read(8'h61, 8'h00);
      reg_read(8'h66, 8'h00);
      check("pin drive", {7'h00, addr_pin_oe_b}, 8'h01);
      check("pin out", {7'h00, addr_pin_out}, 8'h00);
      check("dither exp", {3'h0, dither_exp}, 8'h09);
      check("dither en", {6'h00, dither_main_en, dither_second_en}, 8'h03);
      check("matching", {7'h00, dynamic_element_matching_en}, 8'h01);
      count_mod(15, "slow modulator rate");
      reg_write(8'h5d, 8'h78);
      count_mod(30, "fast modulator rate");
      $display("reset values and modulator rate done");
      for (int e = 0; e < 4; e++) begin
         reg_write(8'h5d, {1'b1, 2'(e), 3'b110, 2'b00});
         @(negedge sys_clk);
         check("dither en", {6'h00, dither_main_en, dither_second_en}, {6'h00, 1'(e), 1'(e >> 1)});
      end
      for (int l = 0; l < 8; l++) begin
         reg_write(8'h5d, {1'b1, 2'b11, 3'(l), 2'b00});
         @(negedge sys_clk);
         check("dither exp", {3'h0, dither_exp}, 8'(l[2] ? 7 + l[1:0] : 13 + l[1:0]));
      end
      for (int m = 0; m < 4; m++) begin
         reg_write(8'h5d, {1'b0, 2'b01, 3'b101, 2'(m)});
         @(negedge sys_clk);
         check("matching", {7'h00, dynamic_element_matching_en}, 8'(m == 0));
      end
      reg_read(8'h5d, 8'h37);
      $display("modulator fields done");
      addr_pin_in = 1'b1;
      repeat (2) @(negedge sys_clk);
      check("pin level", {7'h00, addr_pin_level}, 8'h01);
      reg_write(8'h60, 8'h01);
      reg_read(8'h60, 8'h01);
      check("pin drive", {7'h00, addr_pin_oe_b}, 8'h00);
      addr_pin_in = 1'b0;
      repeat (2) @(negedge sys_clk);
      check("pin level", {7'h00, addr_pin_level}, 8'h01);
      $display("pin direction done");
      foreach (codes[k]) begin
         reg_write(8'h61, {3'b000, codes[k]});
         for (int s = 0; s < 32; s++) begin
            status = 5'(s);
            repeat (2) @(negedge sys_clk);
            check("pin out", {7'h00, addr_pin_out}, {7'h00, exp_pin(codes[k], 5'(s))});
         end
      end
      reg_read(8'h61, 8'h0b);
      $display("pin functions done");
      for (int b = 0; b < 4; b++) begin
         reg_write(8'h66, 8'(1 << b));
         @(negedge sys_clk);
         check("bypass", {4'h0, dsp_bypass}, 8'(1 << b));
      end
      reg_read(8'h66, 8'h08);
      $display("dsp bypass done");
      status = 5'b10001;
      for (int p = 0; p < 4; p++) begin
         power_state_code = 8'(p);
         reg_read(8'h68, 8'(p));
      end
      reg_write(8'h67, 8'h00);
      reg_write(8'h68, 8'h55);
      reg_write(8'h69, 8'h03);
      reg_write(8'h70, 8'hff);
      reg_read(8'h67, ID_VAL);
      reg_read(8'h68, 8'h03);
      reg_read(8'h69, 8'h01);
      status = 5'b01001;
      reg_read(8'h69, 8'h02);
      reg_read(8'h70, 8'h00);
      reg_read(8'h5d, 8'h37);
      $display("read-only registers done");
      do_reset();
      reg_read(8'h5d, 8'hf8);
      reg_read(8'h61, 8'h00);
      check("pin drive", {7'h00, addr_pin_oe_b}, 8'h01);
      $display("second reset done");
      print_verdict();
   end
endmodule
